// [hw/dfl_code_track.v]
// far-end code word framing, validation and removal
`timescale 1ns/1ps
`include "dfl_map.vh"
module dfl_code_track
(
   input wire clock,
   input wire rst_b,
   input wire codeBit,
   input wire codeBitValid,
   output reg [5:0] heldCode_q,
   output reg held_q,
   output reg valPulse_q,
   output reg remPulse_q
);
   reg [15:0] sr_q;
   reg [5:0] hist_q [0:`DFL_CODE_DEPTH-1];
   reg [`DFL_CODE_DEPTH-1:0] histV_q;
   reg chk_q;
   reg [3:0] eqNew;
   reg [3:0] diffHeld;
   wire [15:0] srNext;
   wire hit;
   integer i;
   integer j;
   // ----------------------------------------------------------------
   // eight ones, zero, six code bits, zero; first bit is oldest
   // ----------------------------------------------------------------
   assign srNext = {sr_q[14:0], codeBit};
   assign hit = codeBitValid && srNext[15:8] == 8'hff &&
      !srNext[7] && !srNext[0];
   always @*
   begin
      eqNew = 4'd0;
      diffHeld = 4'd0;
      for (i = 0; i < `DFL_CODE_DEPTH; i = i + 1)
      begin
         if (histV_q[i] && hist_q[i] == hist_q[0])
            eqNew = eqNew + 4'd1;
         if (histV_q[i] && hist_q[i] != heldCode_q)
            diffHeld = diffHeld + 4'd1;
      end
   end
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sr_q <= 16'h0000;
         histV_q <= {`DFL_CODE_DEPTH{1'b0}};
         chk_q <= 1'b0;
         heldCode_q <= 6'h00;
         held_q <= 1'b0;
         valPulse_q <= 1'b0;
         remPulse_q <= 1'b0;
         for (j = 0; j < `DFL_CODE_DEPTH; j = j + 1)
            hist_q[j] <= 6'h00;
      end
      else
      begin
         valPulse_q <= 1'b0;
         remPulse_q <= 1'b0;
         chk_q <= hit;
         if (hit)
         begin
            // cleared so an all-ones code cannot frame twice
            sr_q <= 16'h0000;
            hist_q[0] <= {srNext[1], srNext[2], srNext[3],
               srNext[4], srNext[5], srNext[6]};
            histV_q <= {histV_q[`DFL_CODE_DEPTH-2:0], 1'b1};
            for (j = 1; j < `DFL_CODE_DEPTH; j = j + 1)
               hist_q[j] <= hist_q[j-1];
         end
         else if (codeBitValid)
            sr_q <= srNext;
         if (chk_q)
         begin
            if (held_q && diffHeld >= `DFL_CODE_REMOVE_MIN)
            begin
               held_q <= 1'b0;
               remPulse_q <= 1'b1;
            end
            else if (!held_q && eqNew >= `DFL_CODE_VALID_MIN)
            begin
               heldCode_q <= hist_q[0];
               held_q <= 1'b1;
               valPulse_q <= 1'b1;
            end
         end
      end
   end
endmodule // dfl_code_track

// [hw/dfl_crc16.v]
// byte-wide frame check sequence engine, bits taken lsb first
`timescale 1ns/1ps
`include "dfl_map.vh"
module dfl_crc16
(
   input wire clock,
   input wire rst_b,
   input wire init,
   input wire en,
   input wire [7:0] dataByte,
   output reg [15:0] crc_q
);
   reg [15:0] crc_d;
   reg fb;
   integer i;
   // ----------------------------------------------------------------
   // x16 + x12 + x5 + 1, reflected form
   // ----------------------------------------------------------------
   always @*
   begin
      crc_d = crc_q;
      fb = 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
         fb = crc_d[0] ^ dataByte[i];
         crc_d = {1'b0, crc_d[15:1]} ^ (fb ? `DFL_CRC_POLY : 16'h0000);
      end
   end
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         crc_q <= `DFL_CRC_INIT;
      else if (init)
         crc_q <= `DFL_CRC_INIT;
      else if (en)
         crc_q <= crc_d;
   end
endmodule // dfl_crc16

// [hw/dfl_map.vh]
// register map, field positions, reset values and link constants
`ifndef DFL_MAP_VH
`define DFL_MAP_VH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DFL_IDX_CODE 9'h016
`define DFL_IDX_CODE_IRQ 9'h017
`define DFL_IDX_MSG_CTRL 9'h018
`define DFL_IDX_MSG_STAT 9'h019
`define DFL_IDX_RAM_FIRST 9'h0de
`define DFL_IDX_RAM_LAST 9'h135
`define DFL_RAM_DEPTH 88
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DFL_B_VAL_IRQ 0
`define DFL_B_VAL_EN 1
`define DFL_B_REM_IRQ 2
`define DFL_B_REM_EN 3
`define DFL_B_HELD 4
`define DFL_B_MSG_IRQ 0
`define DFL_B_MSG_EN 1
`define DFL_B_RX_ON 2
`define DFL_B_CR 1
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DFL_RST_VAL_EN 1'b0
`define DFL_RST_REM_EN 1'b0
`define DFL_RST_MSG_EN 1'b0
`define DFL_RST_RX_ON 1'b0
// ----------------------------------------------------------------
// code word tracking and message framing
// ----------------------------------------------------------------
`define DFL_CODE_DEPTH 10
`define DFL_CODE_VALID_MIN 4'd8
`define DFL_CODE_REMOVE_MIN 4'd3
`define DFL_FLAG 8'h7e
`define DFL_HDR_BYTES 8'd3
`define DFL_TAIL_BYTES 8'd5
`define DFL_CRC_INIT 16'hffff
`define DFL_CRC_POLY 16'h8408
`define DFL_CRC_GOOD 16'hf0b8
`define DFL_TYPE_TEST 8'h32
`define DFL_TYPE_IDLE 8'h34
`define DFL_TYPE_CL 8'h38
`define DFL_TYPE_ITU 8'h3f
`define DFL_RESP_OKAY 2'b00
`define DFL_RESP_SLVERR 2'b10
`endif

// [hw/dfl_rx_top.v]
// receive data link controller: code words, messages, axi4-lite regs
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "dfl_map.vh"
module dfl_rx_top
(
   input wire clock,
   input wire rst_b,
   input wire codeBit,
   input wire codeBitValid,
   input wire linkBit,
   input wire linkBitValid,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg irq_q
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   wire [5:0] heldCode;
   wire codeHeld;
   wire codeValPulse;
   wire codeRemPulse;
   wire [15:0] crc;
   reg valEn_q, remEn_q, valIrq_q, remIrq_q;
   reg rxOn_q, msgEn_q, msgIrq_q;
   reg flagSeen_q, abortSeen_q, crOrigin_q, fcsBad_q, msgDone_q;
   reg [1:0] kind_q;
   reg [2:0] ones_q;
   reg [7:0] raw_q;
   reg [3:0] rawCnt_q;
   reg inFrame_q;
   reg [7:0] byte_q;
   reg [2:0] bitCnt_q;
   reg [7:0] byteCnt_q;
   reg [7:0] b1_q, b2_q;
   reg diff_q;
   reg [7:0] prevLen_q;
   reg [7:0] msgRam [0:`DFL_RAM_DEPTH-1];
   reg awHeld_q, wHeld_q;
   reg [8:0] awIdx_q;
   reg [7:0] wData_q;
   reg wLane_q;
   reg [31:0] rdMux;
   reg rdOk;
   wire [8:0] arIdx, ramIdx;
   wire arTake, wrGo, rdCode, rdMsgCtrl;
   wire [7:0] statByte;
   wire linkEn, stuff, abortNow, byteDone, closing;
   wire [7:0] rawNext, fullByte, infoIdx, infoLen;
   wire isFlag, ramWr, eomIrqSet;

   // ----------------------------------------------------------------
   // code word tracker and check sequence engine
   // ----------------------------------------------------------------
   dfl_code_track u_code
   (
      .clock(clock),
      .rst_b(rst_b),
      .codeBit(codeBit),
      .codeBitValid(codeBitValid),
      .heldCode_q(heldCode),
      .held_q(codeHeld),
      .valPulse_q(codeValPulse),
      .remPulse_q(codeRemPulse)
   );

   dfl_crc16 u_crc
   (
      .clock(clock),
      .rst_b(rst_b),
      .init(linkEn && isFlag),
      .en(byteDone),
      .dataByte(fullByte),
      .crc_q(crc)
   );

   // ----------------------------------------------------------------
   // link bit decode
   // ----------------------------------------------------------------
   // the framer hands over only the three link bits of frame five
   assign linkEn = linkBitValid && rxOn_q;
   assign rawNext = {linkBit, raw_q[7:1]};
   assign isFlag = rawNext == `DFL_FLAG;
   assign abortNow = linkEn && linkBit && ones_q == 3'd6;
   assign stuff = !linkBit && ones_q == 3'd5;
   assign fullByte = {linkBit, byte_q[7:1]};
   assign byteDone = linkEn && inFrame_q && !isFlag && !abortNow &&
      !stuff && bitCnt_q == 3'd7;
   assign closing = linkEn && isFlag && inFrame_q &&
      byteCnt_q > `DFL_TAIL_BYTES;
   // two newest bytes held back: they may be the check sequence
   assign infoIdx = byteCnt_q - `DFL_TAIL_BYTES;
   assign infoLen = byteCnt_q - `DFL_TAIL_BYTES;
   assign ramWr = byteDone && byteCnt_q >= `DFL_TAIL_BYTES &&
      infoIdx < 8'd88;
   assign eomIrqSet = closing && (diff_q || infoLen != prevLen_q);

   always @(posedge clock)
   begin
      if (ramWr)
         msgRam[infoIdx[6:0]] <= b2_q;
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ones_q <= 3'd0;
         raw_q <= 8'h00;
         rawCnt_q <= 4'd0;
         inFrame_q <= 1'b0;
         byte_q <= 8'h00;
         bitCnt_q <= 3'd0;
         byteCnt_q <= 8'd0;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         diff_q <= 1'b0;
         prevLen_q <= 8'd0;
         flagSeen_q <= 1'b0;
         abortSeen_q <= 1'b0;
         crOrigin_q <= 1'b0;
         fcsBad_q <= 1'b0;
         msgDone_q <= 1'b0;
         kind_q <= 2'b00;
      end
      else if (!rxOn_q)
      begin
         inFrame_q <= 1'b0;
         ones_q <= 3'd0;
         raw_q <= 8'h00;
      end
      else if (linkEn)
      begin
         raw_q <= rawNext;
         if (linkBit && ones_q != 3'd7)
            ones_q <= ones_q + 3'd1;
         else if (!linkBit)
            ones_q <= 3'd0;
         if (isFlag)
         begin
            flagSeen_q <= 1'b1;
            rawCnt_q <= 4'd0;
            inFrame_q <= 1'b1;
            bitCnt_q <= 3'd0;
            byteCnt_q <= 8'd0;
            diff_q <= 1'b0;
         end
         else
         begin
            if (rawCnt_q != 4'd8)
               rawCnt_q <= rawCnt_q + 4'd1;
            if (rawCnt_q == 4'd7)
               flagSeen_q <= 1'b0;
         end
         if (closing)
         begin
            msgDone_q <= 1'b1;
            fcsBad_q <= crc != `DFL_CRC_GOOD;
            prevLen_q <= infoLen;
         end
         if (abortNow && inFrame_q)
         begin
            abortSeen_q <= 1'b1;
            inFrame_q <= 1'b0;
         end
         if (inFrame_q && !isFlag && !stuff)
         begin
            byte_q <= fullByte;
            bitCnt_q <= bitCnt_q + 3'd1;
         end
         if (byteDone)
         begin
            b1_q <= fullByte;
            b2_q <= b1_q;
            if (byteCnt_q != 8'hff)
               byteCnt_q <= byteCnt_q + 8'd1;
            if (ramWr && msgRam[infoIdx[6:0]] != b2_q)
               diff_q <= 1'b1;
            if (byteCnt_q == 8'd0)
            begin
               crOrigin_q <= fullByte[`DFL_B_CR];
               abortSeen_q <= 1'b0;
               msgDone_q <= 1'b0;
            end
            if (byteCnt_q == `DFL_HDR_BYTES)
            begin
               case (fullByte)
                  `DFL_TYPE_TEST: kind_q <= 2'b00;
                  `DFL_TYPE_IDLE: kind_q <= 2'b01;
                  `DFL_TYPE_CL: kind_q <= 2'b10;
                  `DFL_TYPE_ITU: kind_q <= 2'b11;
                  default: kind_q <= kind_q;
               endcase
            end
         end
      end
   end

   assign statByte = {1'b0, abortSeen_q, kind_q, crOrigin_q, fcsBad_q,
      msgDone_q, flagSeen_q};

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   assign arIdx = s_axi_araddr[10:2];
   assign ramIdx = arIdx - `DFL_IDX_RAM_FIRST;
   assign arTake = s_axi_arvalid && s_axi_arready;
   assign wrGo = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign rdCode = arTake && arIdx == `DFL_IDX_CODE_IRQ;
   assign rdMsgCtrl = arTake && arIdx == `DFL_IDX_MSG_CTRL;

   always @*
   begin
      rdMux = 32'h00000000;
      rdOk = 1'b1;
      if (s_axi_araddr[11] || s_axi_araddr[1:0] != 2'b00)
         rdOk = 1'b0;
      else if (arIdx == `DFL_IDX_CODE)
         rdMux = {24'h000000, 1'b0, heldCode, 1'b0};
      else if (arIdx == `DFL_IDX_CODE_IRQ)
         rdMux = {27'h0, codeHeld, remEn_q, remIrq_q, valEn_q,
            valIrq_q};
      else if (arIdx == `DFL_IDX_MSG_CTRL)
         rdMux = {29'h0, rxOn_q, msgEn_q, msgIrq_q};
      else if (arIdx == `DFL_IDX_MSG_STAT)
         rdMux = {24'h000000, statByte};
      else if (arIdx >= `DFL_IDX_RAM_FIRST &&
         arIdx <= `DFL_IDX_RAM_LAST)
         rdMux = {24'h000000, msgRam[ramIdx[6:0]]};
      else
         rdOk = 1'b0;
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awIdx_q <= 9'h000;
         wData_q <= 8'h00;
         wLane_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DFL_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DFL_RESP_OKAY;
         valEn_q <= `DFL_RST_VAL_EN;
         remEn_q <= `DFL_RST_REM_EN;
         msgEn_q <= `DFL_RST_MSG_EN;
         rxOn_q <= `DFL_RST_RX_ON;
      end
      else
      begin
         // address and data may arrive in either order
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            s_axi_awready <= 1'b0;
            awIdx_q <= s_axi_awaddr[11] ? 9'h1ff : s_axi_awaddr[10:2];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wData_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
         end
         if (wrGo)
         begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `DFL_RESP_OKAY;
            if (awIdx_q == `DFL_IDX_CODE_IRQ && wLane_q)
            begin
               remEn_q <= wData_q[`DFL_B_REM_EN];
               valEn_q <= wData_q[`DFL_B_VAL_EN];
            end
            else if (awIdx_q == `DFL_IDX_MSG_CTRL && wLane_q)
            begin
               rxOn_q <= wData_q[`DFL_B_RX_ON];
               msgEn_q <= wData_q[`DFL_B_MSG_EN];
            end
            else if (awIdx_q != `DFL_IDX_CODE &&
               awIdx_q != `DFL_IDX_MSG_STAT &&
               awIdx_q != `DFL_IDX_CODE_IRQ &&
               awIdx_q != `DFL_IDX_MSG_CTRL)
               s_axi_bresp <= `DFL_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (arTake)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? `DFL_RESP_OKAY : `DFL_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky status and interrupt request
   // ----------------------------------------------------------------
   // a set landing on the clearing read wins, so no event is lost
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         valIrq_q <= 1'b0;
         remIrq_q <= 1'b0;
         msgIrq_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         valIrq_q <= codeValPulse || (valIrq_q && !rdCode);
         remIrq_q <= codeRemPulse || (remIrq_q && !rdCode);
         msgIrq_q <= eomIrqSet || (msgIrq_q && !rdMsgCtrl);
         irq_q <= (valIrq_q && valEn_q) || (remIrq_q && remEn_q) ||
            (msgIrq_q && msgEn_q);
      end
   end
endmodule // dfl_rx_top

// [verif/dfl_framer_model.sv]
// behavioural receive framer: code channel and overhead link bits
`timescale 1ns/1ps
module dfl_framer_model
(
   input wire clock,
   output reg codeBit = 1'b0,
   output reg codeBitValid = 1'b0,
   output reg linkBit = 1'b0,
   output reg linkBitValid = 1'b0
);
   integer onesRun = 0;
   // ----
   // bit delivery
   // ----
   // after the strobe the line shows the inverse, so a stale bit
   // can never pass for a fresh one
   task putBit(input reg b, input reg code);
   begin
      @(posedge clock);
      if (code) codeBit <= b;
      else linkBit <= b; // only frame-five link bits reach here
      codeBitValid <= code;
      linkBitValid <= !code;
      @(posedge clock);
      codeBitValid <= 1'b0;
      linkBitValid <= 1'b0;
      if (code) codeBit <= ~b;
      else linkBit <= ~b;
   end
   endtask
   // flags go unstuffed; the run of ones spans octets
   task sendOctet(input [7:0] v, input reg stuff);
      integer i;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         putBit(v[i], 1'b0);
         onesRun = (stuff && v[i]) ? onesRun + 1 : 0;
         if (onesRun == 5)
         begin
            putBit(1'b0, 1'b0); // zero after five ones
            onesRun = 0;
         end
      end
   end
   endtask
   // eight ones, a zero, the word low bit first, a closing zero
   task sendCode(input [5:0] w);
      integer i;
   begin
      for (i = 0; i < 8; i = i + 1)
         putBit(1'b1, 1'b1);
      putBit(1'b0, 1'b1);
      for (i = 0; i < 6; i = i + 1)
         putBit(w[i], 1'b1);
      putBit(1'b0, 1'b1);
   end
   endtask
endmodule // dfl_framer_model

// [verif/dfl_rx_props.sv]
// assertions on the receive controller's register port
`timescale 1ns/1ps
module dfl_rx_props
(
   input wire clock,
   input wire rst_b,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire irq_q
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // ----
   // handshake timing and read data
   // ----
   write_answer_time_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer off time");
   write_busy_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel open during answer");
   write_release_a: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write answer not released");
   read_answer_time_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer off time");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open during answer");
   read_release_a: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not released");
   code_pad_zero_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h058
      |=> s_axi_rdata[7] == 1'b0 && s_axi_rdata[0] == 1'b0 &&
      s_axi_rdata[31:8] == 24'h0) else $error("code padding not zero");
   unmapped_err_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   cover property ($rose(irq_q));
   cover property (s_axi_rvalid && s_axi_rdata[1]);
   cover property (s_axi_rvalid && s_axi_rdata[6]);
endmodule // dfl_rx_props

bind dfl_rx_top dfl_rx_props u_props
(
   .clock(clock), .rst_b(rst_b), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .irq_q(irq_q)
);

// [verif/testbench.sv]
// self-checking bench for the receive data link controller
`timescale 1ns/1ps
`include "dfl_map.vh"
`define TB_CHK(got, exp) \
begin \
   n_tests = n_tests + 1; \
   if ((got) !== (exp)) \
   begin \
      fail_count = fail_count + 1; \
      $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); \
   end \
end
module testbench;
   reg clock = 1'b0;
   reg rst_b = 1'b0;
   reg [11:0] awaddr = 12'h0;
   reg [11:0] araddr = 12'h0;
   reg [31:0] wdata = 32'h0;
   reg awvalid = 1'b0;
   reg wvalid = 1'b0;
   reg bready = 1'b0;
   reg arvalid = 1'b0;
   reg rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire codeBit, codeBitValid, linkBit, linkBitValid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer fail_count = 0;
   integer n_tests = 0;
   integer i, j, k, len, seedTmp;
   reg [1:0] bResp, rdResp;
   reg [31:0] rdVal;
   reg [5:0] w1, w2;
   reg [7:0] kind, expStat;
   reg [15:0] crc;
   reg [7:0] frame[$];
   reg [7:0] info[$];

   dfl_rx_top DUT
   (
      .clock(clock), .rst_b(rst_b), .codeBit(codeBit),
      .codeBitValid(codeBitValid), .linkBit(linkBit),
      .linkBitValid(linkBitValid), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq_q(irq)
   );
   dfl_framer_model frm
   (
      .clock(clock), .codeBit(codeBit), .codeBitValid(codeBitValid),
      .linkBit(linkBit), .linkBitValid(linkBitValid)
   );
   always #25 clock = ~clock;
   // ----
   // bus master and frame builder
   // ----
   task axiWrite(input [11:0] a, input [7:0] d);
   begin
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      bResp = bresp;
      bready <= 1'b0;
   end
   endtask
   task axiRead(input [11:0] a);
   begin
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      rdVal = rdata;
      rdResp = rresp;
      rready <= 1'b0;
   end
   endtask
   task rdChk(input [11:0] a, input [7:0] exp);
   begin
      axiRead(a);
      `TB_CHK(rdVal, {24'h0, exp})
   end
   endtask
   task sendFrame(input [7:0] adr, input reg bad);
   begin
      info = {kind}; // type byte leads the payload
      for (k = 1; k < len; k = k + 1)
         info.push_back(8'($urandom));
      info[1] = 8'hff; // forces a stuffed zero
      frame = {adr, 8'h01, 8'h03};
      frame = {frame, info};
      crc = `DFL_CRC_INIT;
      for (k = 0; k < frame.size(); k = k + 1)
         for (j = 0; j < 8; j = j + 1)
            crc = (crc >> 1) ^
               ((crc[0] ^ frame[k][j]) ? `DFL_CRC_POLY : 16'h0);
      crc = ~crc ^ {15'h0, bad}; // sent complemented, low octet first
      frame.push_back(crc[7:0]);
      frame.push_back(crc[15:8]);
      frm.sendOctet(`DFL_FLAG, 1'b0);
      for (k = 0; k < frame.size(); k = k + 1)
         frm.sendOctet(frame[k], 1'b1);
      frm.sendOctet(`DFL_FLAG, 1'b0);
      repeat (3) @(posedge clock);
   end
   endtask
   task end_of_test;
   begin
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   // ----
   // scenarios
   // ----
   initial
   begin
      seedTmp = $urandom(82);
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
         rdChk(12'h058 + 12'(4 * i), 8'h00);
      rdChk(12'h000, 8'h00);
      `TB_CHK(rdResp, `DFL_RESP_SLVERR)
      axiWrite(12'h000, 8'hff);
      `TB_CHK(bResp, `DFL_RESP_SLVERR)
      axiWrite(12'h064, 8'hff);
      `TB_CHK(bResp, `DFL_RESP_OKAY)
      frm.sendOctet(`DFL_FLAG, 1'b0);
      repeat (3) @(posedge clock);
      rdChk(12'h064, 8'h00); // receiver still off
      w1 = 6'($urandom);
      w2 = w1 ^ 6'h2d;
      axiWrite(12'h05c, 8'h0a);
      repeat (7) frm.sendCode(w1);
      repeat (4) @(posedge clock);
      rdChk(12'h05c, 8'h0a); // seven of ten is short
      frm.sendCode(w1);
      repeat (4) @(posedge clock);
      `TB_CHK(irq, 1'b1)
      rdChk(12'h058, {1'b0, w1, 1'b0});
      rdChk(12'h05c, 8'h1b);
      rdChk(12'h05c, 8'h1a);
      repeat (2) frm.sendCode(w2);
      repeat (4) @(posedge clock);
      rdChk(12'h05c, 8'h1a); // two differing codes keep it
      frm.sendCode(w2);
      repeat (4) @(posedge clock);
      `TB_CHK(irq, 1'b1)
      rdChk(12'h05c, 8'h0e);
      rdChk(12'h058, {1'b0, w1, 1'b0});
      rdChk(12'h05c, 8'h0a);
      repeat (2) @(posedge clock);
      `TB_CHK(irq, 1'b0)
      axiWrite(12'h060, 8'h06);
      rdChk(12'h060, 8'h06);
      for (i = 0; i < 4; i = i + 1)
      begin
         kind = (i == 0) ? `DFL_TYPE_TEST : (i == 1) ? `DFL_TYPE_IDLE :
            (i == 2) ? `DFL_TYPE_CL : `DFL_TYPE_ITU;
         len = (i == 3) ? 82 : 76;
         sendFrame(i[0] ? 8'h3e : 8'h3c, i == 2);
         `TB_CHK(irq, 1'b1)
         expStat = {2'b00, i[1:0], i[0], i == 2, 2'b11};
         rdChk(12'h064, expStat);
         rdChk(12'h060, 8'h07);
         rdChk(12'h060, 8'h06);
         for (k = 0; k < len; k = k + 1)
            rdChk(12'h378 + 12'(4 * k), info[k]);
         `TB_CHK(irq, 1'b0)
      end
      frm.sendOctet(`DFL_FLAG, 1'b0);
      frm.sendOctet(8'hff, 1'b0);
      repeat (3) @(posedge clock);
      axiRead(12'h064);
      `TB_CHK(rdVal[6], 1'b1)
      `TB_CHK(rdVal[0], 1'b0)
      end_of_test;
   end
   // about 7000 cycles expected; the limit leaves ample margin
   initial
   begin
      #(50 * 60000);
      fail_count = fail_count + 1;
      end_of_test;
   end
endmodule // testbench
